// >>> pkg/pfmg_pkg.sv
// Shared constants for the pin function multiplexer and its synchroniser.
// Assumes a single core clock and an active low asynchronous reset.
package pfmg_pkg;
  // Function selection field
  localparam int SEL_W = 2;
  localparam logic [1:0] SEL_GPIO = 2'h0;
  localparam logic [1:0] SEL_ALT1 = 2'h1;
  localparam logic [1:0] SEL_ALT2 = 2'h2;
  localparam logic [1:0] SEL_RSVD = 2'h3;
  localparam int NUM_ALT = 2;
  // Power emulation field
  localparam logic PWR_STANDBY = 1'h0;
  localparam logic PWR_RUNTIME = 1'h1;
  // Reset values of the per-pin configuration
  localparam logic RST_PWR = PWR_STANDBY;
  localparam logic RST_DIR = 1'h0;
  localparam logic RST_OD = 1'h0;
  localparam logic RST_DOUT = 1'h0;
  // Input synchroniser depth
  localparam int SYNC_STAGES = 3;
endpackage : pfmg_pkg

// >>> pkg/pfmg_sync_if.sv
// Carries raw pin levels into the synchroniser and stable levels back.
// Assumes both ends share the core clock.
interface pfmg_sync_if #(
  parameter int W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] stable;
  modport src (output raw, input stable);
  modport snk (input raw, output stable);
endinterface : pfmg_sync_if

// >>> hw/pfmg_sync.sv
// Three-stage synchroniser with agreement filter for pad inputs.
// Assumes raw levels are asynchronous to i_core_clk.
module pfmg_sync
  import pfmg_pkg::*;
#(
  parameter int W = 1
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_rstn, // Async reset, active low
  pfmg_sync_if.snk bus // Raw in, stable out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } pfmg_sync_st_t;

  pfmg_sync_st_t st_reg;
  pfmg_sync_st_t st_next;

  // Shift chain; accept a level once stages two and three agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = bus.raw;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.stable[i] = st_reg.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus.stable = st_reg.stable;
endmodule : pfmg_sync

// >>> hw/pfmg_top.sv
// Pin function multiplexer with power-well emulation and input gating.
// Assumes firmware drives the configuration ports synchronously to i_core_clk
// and that the pad ring resolves pad level from o_pad_out and o_pad_oe.
// What this block does
// - Each general pin connects to the signal chosen by its current selection field.
// - Reset loads every selection field with that pin's default assignment.
// - Fixed pins carry one function and have no selection field.
// - General pins have a programmable buffer with direction and open-drain set by firmware while GPIO is selected.
// - Some alternate functions force their own buffer type over the general configuration.
// - After standby rail power-up pins follow defaults and accept reprogramming.
// - General pins take their power-well emulation from their power field.
// - Fixed pins have a per-signal power-well emulation that is not programmable.
// - An input is held at its gated value when its well is off or it is not selected.
// - An ungated input follows the pad at all times.
// - Gated values of output functions never change what the pad drives.
// - Outputs emulating the runtime domain float while runtime supply good is low.
module pfmg_top
  import pfmg_pkg::*;
#(
  parameter int NUM_PINS = 8,
  parameter int NUM_FIX = 2,
  parameter logic [NUM_PINS*SEL_W-1:0] DEFAULT_SEL = '0,
  parameter logic [NUM_PINS-1:0] GPIO_UNGATED = '1,
  parameter logic [NUM_ALT*NUM_PINS-1:0] ALT_GATE_VAL = '1,
  parameter logic [NUM_ALT*NUM_PINS-1:0] ALT_UNGATED = '0,
  parameter logic [NUM_ALT*NUM_PINS-1:0] ALT_FORCE_OD = '0,
  parameter logic [NUM_FIX-1:0] FIX_PWR = '0,
  parameter logic [NUM_FIX-1:0] FIX_GATE_VAL = '0,
  parameter logic [NUM_FIX-1:0] FIX_UNGATED = '0,
  parameter int IW = (NUM_PINS > 1) ? $clog2(NUM_PINS) : 1
) (
  input wire logic i_core_clk, // Core clock, 200 MHz
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_runtime_supply_good, // Runtime supply good pin
  input wire logic [NUM_PINS-1:0] i_pad_in, // General pad levels
  output logic [NUM_PINS-1:0] o_pad_out, // General pad drive value
  output logic [NUM_PINS-1:0] o_pad_oe, // General pad drive enable
  input wire logic [NUM_FIX-1:0] i_fix_pad_in, // Fixed pad levels
  output logic [NUM_FIX-1:0] o_fix_pad_out, // Fixed pad drive value
  output logic [NUM_FIX-1:0] o_fix_pad_oe, // Fixed pad drive enable
  input wire logic i_cfg_we, // Configuration write strobe
  input wire logic [IW-1:0] i_cfg_idx, // Pin written
  input wire logic [SEL_W-1:0] i_cfg_sel, // Function selection
  input wire logic i_cfg_pwr, // Power emulation select
  input wire logic i_cfg_dir, // 1 = output
  input wire logic i_cfg_od, // 1 = open drain
  input wire logic i_cfg_dout, // General output value
  input wire logic [IW-1:0] i_rd_idx, // Pin read back
  output logic [SEL_W-1:0] o_rd_sel, // Read-back selection
  output logic o_rd_pwr, // Read-back power select
  output logic o_rd_dir, // Read-back direction
  output logic o_rd_od, // Read-back open drain
  output logic o_rd_dout, // Read-back output value
  output logic o_rd_pad, // Read-back synced pad level
  output logic [NUM_PINS-1:0] o_gpio_in, // General input to core
  input wire logic [NUM_ALT*NUM_PINS-1:0] i_alt_out, // Alternate output values
  input wire logic [NUM_ALT*NUM_PINS-1:0] i_alt_oe, // Alternate output enables
  output logic [NUM_ALT*NUM_PINS-1:0] o_alt_in, // Alternate inputs to core
  input wire logic [NUM_FIX-1:0] i_fix_out, // Fixed function output values
  input wire logic [NUM_FIX-1:0] i_fix_oe, // Fixed function output enables
  output logic [NUM_FIX-1:0] o_fix_in // Fixed function inputs to core
);
  localparam int SW = NUM_PINS + NUM_FIX + 1;

  typedef struct packed {
    logic [NUM_PINS-1:0][SEL_W-1:0] sel;
    logic [NUM_PINS-1:0] pwr;
    logic [NUM_PINS-1:0] dir;
    logic [NUM_PINS-1:0] od;
    logic [NUM_PINS-1:0] dout;
    logic [NUM_PINS-1:0] pad_out;
    logic [NUM_PINS-1:0] pad_oe;
    logic [NUM_PINS-1:0] gpio_in;
    logic [NUM_ALT*NUM_PINS-1:0] alt_in;
    logic [NUM_FIX-1:0] fix_out;
    logic [NUM_FIX-1:0] fix_oe;
    logic [NUM_FIX-1:0] fix_in;
    logic [SEL_W-1:0] rd_sel;
    logic rd_pwr;
    logic rd_dir;
    logic rd_od;
    logic rd_dout;
    logic rd_pad;
  } pfmg_st_t;

  pfmg_st_t st_reg;
  pfmg_st_t st_next;
  logic [NUM_PINS-1:0] pad_s;
  logic [NUM_FIX-1:0] fix_s;
  logic pg_s;

  // Emulated well is up for standby rail, or runtime with supply good
  function automatic logic well_on(input logic pwr, input logic pg);
    well_on = (pwr == PWR_STANDBY) || pg;
  endfunction : well_on

  // Pad and supply-good inputs through the synchroniser
  pfmg_sync_if #(.W(SW)) sync_bus ();
  assign sync_bus.raw = {i_runtime_supply_good, i_fix_pad_in, i_pad_in};
  assign pad_s = sync_bus.stable[NUM_PINS-1:0];
  assign fix_s = sync_bus.stable[NUM_PINS+NUM_FIX-1:NUM_PINS];
  assign pg_s = sync_bus.stable[SW-1];

  pfmg_sync #(.W(SW)) u_sync (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .bus(sync_bus)
  );

  // Configuration, pin multiplexing, gating and read-back
  always_comb begin
    logic on;
    logic val;
    logic oe;
    int a;
    on = 1'b0;
    val = 1'b0;
    oe = 1'b0;
    a = 0;
    st_next = st_reg;
    // Firmware may rewrite any field at any time after reset
    if (i_cfg_we) begin
      st_next.sel[i_cfg_idx] = i_cfg_sel;
      st_next.pwr[i_cfg_idx] = i_cfg_pwr;
      st_next.dir[i_cfg_idx] = i_cfg_dir;
      st_next.od[i_cfg_idx] = i_cfg_od;
      st_next.dout[i_cfg_idx] = i_cfg_dout;
    end
    for (int p = 0; p < NUM_PINS; p++) begin
      on = well_on(st_reg.pwr[p], pg_s);
      val = 1'b0;
      oe = 1'b0;
      case (st_reg.sel[p])
        SEL_GPIO: begin
          // Programmable buffer, push-pull or open drain
          if (st_reg.dir[p]) begin
            if (st_reg.od[p]) begin
              oe = !st_reg.dout[p];
            end else begin
              oe = 1'b1;
              val = st_reg.dout[p];
            end
          end
        end
        SEL_ALT1, SEL_ALT2: begin
          a = (st_reg.sel[p] == SEL_ALT1) ? 0 : 1;
          val = i_alt_out[a*NUM_PINS+p];
          oe = i_alt_oe[a*NUM_PINS+p];
          // Function-defined open-drain buffer
          if (ALT_FORCE_OD[a*NUM_PINS+p]) begin
            oe = oe && !val;
            val = 1'b0;
          end
        end
        default: begin
          oe = 1'b0; // Reserved code drives nothing
        end
      endcase
      // Runtime-emulated outputs float without supply good
      if (!on) begin
        oe = 1'b0;
      end
      // Pad drive ignores any gated values
      st_next.pad_out[p] = val;
      st_next.pad_oe[p] = oe;
      // General input: ungated pins follow the pad
      if (GPIO_UNGATED[p] || (on && st_reg.sel[p] == SEL_GPIO)) begin
        st_next.gpio_in[p] = pad_s[p];
      end else begin
        st_next.gpio_in[p] = 1'b0;
      end
      // Alternate inputs gated unless selected and powered
      for (int k = 0; k < NUM_ALT; k++) begin
        if (ALT_UNGATED[k*NUM_PINS+p]) begin
          st_next.alt_in[k*NUM_PINS+p] = pad_s[p];
        end else if (on && st_reg.sel[p] == ((k == 0) ? SEL_ALT1 : SEL_ALT2)) begin
          st_next.alt_in[k*NUM_PINS+p] = pad_s[p];
        end else begin
          st_next.alt_in[k*NUM_PINS+p] = ALT_GATE_VAL[k*NUM_PINS+p];
        end
      end
    end
    // Fixed pins: one function, fixed emulation
    for (int f = 0; f < NUM_FIX; f++) begin
      on = well_on(FIX_PWR[f], pg_s);
      st_next.fix_out[f] = i_fix_out[f];
      st_next.fix_oe[f] = i_fix_oe[f] && on;
      if (FIX_UNGATED[f] || on) begin
        st_next.fix_in[f] = fix_s[f];
      end else begin
        st_next.fix_in[f] = FIX_GATE_VAL[f];
      end
    end
    // Read-back of the addressed pin
    st_next.rd_sel = st_reg.sel[i_rd_idx];
    st_next.rd_pwr = st_reg.pwr[i_rd_idx];
    st_next.rd_dir = st_reg.dir[i_rd_idx];
    st_next.rd_od = st_reg.od[i_rd_idx];
    st_next.rd_dout = st_reg.dout[i_rd_idx];
    st_next.rd_pad = pad_s[i_rd_idx];
  end

  // State register; defaults load on reset
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= '0;
      st_reg.sel <= DEFAULT_SEL;
      st_reg.pwr <= {NUM_PINS{RST_PWR}};
      st_reg.dir <= {NUM_PINS{RST_DIR}};
      st_reg.od <= {NUM_PINS{RST_OD}};
      st_reg.dout <= {NUM_PINS{RST_DOUT}};
      st_reg.alt_in <= ALT_GATE_VAL;
      st_reg.fix_in <= FIX_GATE_VAL;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign o_pad_out = st_reg.pad_out;
  assign o_pad_oe = st_reg.pad_oe;
  assign o_fix_pad_out = st_reg.fix_out;
  assign o_fix_pad_oe = st_reg.fix_oe;
  assign o_gpio_in = st_reg.gpio_in;
  assign o_alt_in = st_reg.alt_in;
  assign o_fix_in = st_reg.fix_in;
  assign o_rd_sel = st_reg.rd_sel;
  assign o_rd_pwr = st_reg.rd_pwr;
  assign o_rd_dir = st_reg.rd_dir;
  assign o_rd_od = st_reg.rd_od;
  assign o_rd_dout = st_reg.rd_dout;
  assign o_rd_pad = st_reg.rd_pad;
endmodule : pfmg_top

// >>> dv/pfmg_props.sv
// Port-level checker for the pin function multiplexer top.
// Assumes default top parameters: general inputs ungated, alternate gate value 1,
// and no forced open-drain buffer on alternate one.
module pfmg_props
  import pfmg_pkg::*;
#(
  parameter int NUM_PINS = 8,
  parameter int NUM_FIX = 2,
  parameter int IW = 3
) (
  input wire logic i_core_clk, // Core clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_runtime_supply_good, // Runtime supply good
  input wire logic [NUM_PINS-1:0] i_pad_in, // General pad levels
  input wire logic [NUM_PINS-1:0] o_pad_out, // Pad drive value
  input wire logic [NUM_PINS-1:0] o_pad_oe, // Pad drive enable
  input wire logic [NUM_FIX-1:0] i_fix_pad_in, // Fixed pad levels
  input wire logic [NUM_FIX-1:0] o_fix_in, // Fixed inputs to core
  input wire logic i_cfg_we, // Write strobe
  input wire logic [IW-1:0] i_cfg_idx, // Pin written
  input wire logic [SEL_W-1:0] i_cfg_sel, // Function written
  input wire logic i_cfg_pwr, // Power select written
  input wire logic [IW-1:0] i_rd_idx, // Pin read back
  input wire logic [SEL_W-1:0] o_rd_sel, // Read-back selection
  input wire logic o_rd_pwr, // Read-back power select
  input wire logic [NUM_PINS-1:0] o_gpio_in, // General inputs to core
  input wire logic [NUM_ALT*NUM_PINS-1:0] i_alt_out, // Alternate drive values
  input wire logic [NUM_ALT*NUM_PINS-1:0] i_alt_oe, // Alternate drive enables
  input wire logic [NUM_ALT*NUM_PINS-1:0] o_alt_in // Alternate inputs to core
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // Configuration storage and pad behaviour
  cfg_store_a: assert property ((i_cfg_we && i_cfg_idx == i_rd_idx) ##1
    (!i_cfg_we && $stable(i_rd_idx)) |=> o_rd_sel == $past(i_cfg_sel, 2)
    && o_rd_pwr == $past(i_cfg_pwr, 2)) else $error("read-back differs from write");
  rsvd_float_a: assert property (o_rd_sel == SEL_RSVD && $stable(i_rd_idx)
    |-> !o_pad_oe[i_rd_idx]) else $error("reserved pin is driven");
  alt_drive_a: assert property ((o_rd_sel == SEL_ALT1 && !o_rd_pwr && $stable(i_rd_idx))[*2]
    |-> o_pad_oe[i_rd_idx] == $past(i_alt_oe[i_rd_idx])
    && o_pad_out[i_rd_idx] == $past(i_alt_out[i_rd_idx])) else $error("alt drive lost");
  runtime_float_a: assert property
    ((o_rd_pwr && !i_runtime_supply_good && $stable(i_rd_idx))[*6]
    |-> !o_pad_oe[i_rd_idx]) else $error("runtime pin drives without supply");
  // Input gating and default selection after reset
  gpio_follow_a: assert property ($stable(i_pad_in)[*7] |-> o_gpio_in == i_pad_in)
    else $error("ungated input not following pad");
  alt_gate_a: assert property ((o_rd_sel == SEL_GPIO && $stable(i_rd_idx))[*2]
    |-> o_alt_in[i_rd_idx] && o_alt_in[NUM_PINS + i_rd_idx]) else $error("alt input not gated");
  fix_follow_a: assert property ($stable(i_fix_pad_in)[*7] |-> o_fix_in == i_fix_pad_in)
    else $error("fixed input not following pad");
  reset_sel_a: assert property ($rose(i_rstn) |=> o_rd_sel == SEL_GPIO)
    else $error("selection not at default after reset");
  cover property (o_rd_sel == SEL_RSVD);
  cover property (o_rd_pwr && !i_runtime_supply_good);
  cover property (o_rd_sel == SEL_ALT2 && |o_pad_oe);
endmodule : pfmg_props

// >>> dv/pfmg_tb_top.sv
// Self-checking bench for the pin function multiplexer top.
// Assumes default top parameters, except one forced open-drain alternate (pin 5,
// alternate two), and a 200 MHz core clock.
module pfmg_tb_top
  import pfmg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rstn = 1'b0, sup = 1'b0, we = 1'b0, pwr = 1'b0, dir = 1'b0, od = 1'b0;
  logic dout = 1'b0, rpwr, rdir, rod, rdout, rpad;
  logic [7:0] pad = 8'h00, pout, poe, gin;
  logic [15:0] aout = 16'h0000, aoe = 16'h0000, ain;
  logic [1:0] fpad = 2'h0, fout = 2'h0, foe = 2'h0, fpo, fpe, fin, sel = 2'h0, rsel;
  logic [2:0] idx = 3'h0, ridx = 3'h0;
  int mismatches = 0, n_compared = 0;
  // Core clock
  always #2.5 clk = ~clk;
  pfmg_top #(.ALT_FORCE_OD(16'h2000)) DUT (.i_core_clk(clk), .i_rstn(rstn),
    .i_runtime_supply_good(sup),
    .i_pad_in(pad), .o_pad_out(pout), .o_pad_oe(poe), .i_fix_pad_in(fpad),
    .o_fix_pad_out(fpo), .o_fix_pad_oe(fpe), .i_cfg_we(we), .i_cfg_idx(idx),
    .i_cfg_sel(sel), .i_cfg_pwr(pwr), .i_cfg_dir(dir), .i_cfg_od(od), .i_cfg_dout(dout),
    .i_rd_idx(ridx), .o_rd_sel(rsel), .o_rd_pwr(rpwr), .o_rd_dir(rdir), .o_rd_od(rod),
    .o_rd_dout(rdout), .o_rd_pad(rpad), .o_gpio_in(gin), .i_alt_out(aout), .i_alt_oe(aoe),
    .o_alt_in(ain), .i_fix_out(fout), .i_fix_oe(foe), .o_fix_in(fin));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // One configuration write, then wait until pads and read-back settle
  task automatic wr(input logic [2:0] i, input logic [1:0] s, input logic [3:0] f);
    @(negedge clk);
    {idx, ridx, sel, we} = {i, i, s, 1'b1};
    {pwr, dir, od, dout} = f;
    @(negedge clk);
    we = 1'b0;
    repeat (3) @(negedge clk);
  endtask : wr
  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      ridx = 3'(i);
      @(negedge clk);
      chk("rd_sel", 16'(SEL_GPIO), 16'(rsel));
    end
    chk("pad_oe", 16'h0000, 16'(poe));
    $display("reset test done");
  endtask : t_reset
  task automatic t_gpio;
    logic [3:0] f [3] = '{4'h5, 4'h7, 4'h6};
    logic [1:0] e [3] = '{2'h3, 2'h0, 2'h2};
    for (int k = 0; k < 3; k++) begin
      wr(3'h1, SEL_GPIO, f[k]);
      chk("rd_cfg", 16'(f[k]), 16'({rpwr, rdir, rod, rdout}));
      chk("pad1_oe_out", 16'(e[k]), 16'({poe[1], pout[1]}));
    end
    $display("general pin test done");
  endtask : t_gpio
  task automatic t_alt;
    logic [1:0] d [3] = '{2'h3, 2'h2, 2'h0};
    logic [1:0] g [3] = '{2'h2, 2'h1, 2'h3};
    {aoe[2], aoe[10], aout[2], aout[10]} = 4'hE;
    for (int s = 1; s < 4; s++) begin
      wr(3'h2, 2'(s), 4'h0);
      chk("rd_sel", 16'(s), 16'(rsel));
      chk("pad2_oe_out", 16'(d[s-1]), 16'({poe[2], pout[2]}));
      chk("alt_in_pin2", 16'(g[s-1]), 16'({ain[10], ain[2]}));
    end
    $display("alternate function test done");
  endtask : t_alt
  // Pins 2 and 3 stay low so gated ones differ from the pad
  task automatic t_gate;
    pad = 8'hF3;
    ridx = 3'h4;
    repeat (6) @(negedge clk);
    chk("gpio_in", 16'h00F3, 16'(gin));
    chk("rd_pad", 16'h0001, 16'(rpad));
    chk("alt_in_rsvd", 16'h0003, 16'({ain[10], ain[2]}));
    $display("gating test done");
  endtask : t_gate
  // Alternate two on pin 5 brings its own open-drain buffer
  task automatic t_odfn;
    {aoe[13], aout[13]} = 2'h3;
    wr(3'h5, SEL_ALT2, 4'h3);
    chk("pad5_od_high", 16'h0000, 16'({poe[5], pout[5]}));
    aout[13] = 1'b0;
    repeat (2) @(negedge clk);
    chk("pad5_od_low", 16'h0002, 16'({poe[5], pout[5]}));
    $display("forced buffer test done");
  endtask : t_odfn
  task automatic t_fix;
    {foe, fout, fpad} = 6'h36;
    repeat (6) @(negedge clk);
    chk("fix_oe_out", 16'h000D, 16'({fpe, fpo}));
    chk("fix_in", 16'h0002, 16'(fin));
    $display("fixed pin test done");
  endtask : t_fix
  task automatic t_pwr;
    {aoe[3], aout[3]} = 2'h3;
    wr(3'h3, SEL_ALT1, 4'h8);
    repeat (6) @(negedge clk);
    chk("rd_pwr", 16'h0001, 16'(rpwr));
    chk("pad3_oe_low", 16'h0000, 16'(poe[3]));
    chk("alt_in_low", 16'h0001, 16'(ain[3]));
    sup = 1'b1;
    repeat (6) @(negedge clk);
    chk("pad3_oe_good", 16'h0001, 16'(poe[3]));
    chk("alt_in_good", 16'h0000, 16'(ain[3]));
    $display("power emulation test done");
  endtask : t_pwr
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_gpio();
    t_alt();
    t_gate();
    t_odfn();
    t_fix();
    t_pwr();
    close_out();
  end
  // Hang guard
  initial begin
    #20us;
    mismatches++;
    close_out();
  end
endmodule : pfmg_tb_top
bind pfmg_top pfmg_props #(.NUM_PINS(NUM_PINS), .NUM_FIX(NUM_FIX), .IW(IW)) u_props (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_runtime_supply_good(i_runtime_supply_good),
  .i_pad_in(i_pad_in), .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe), .i_fix_pad_in(i_fix_pad_in),
  .o_fix_in(o_fix_in), .i_cfg_we(i_cfg_we), .i_cfg_idx(i_cfg_idx), .i_cfg_sel(i_cfg_sel),
  .i_cfg_pwr(i_cfg_pwr), .i_rd_idx(i_rd_idx), .o_rd_sel(o_rd_sel), .o_rd_pwr(o_rd_pwr),
  .o_gpio_in(o_gpio_in), .i_alt_out(i_alt_out), .i_alt_oe(i_alt_oe), .o_alt_in(o_alt_in));
